// [pkg/cls_defs.svh]
// constants of the combo lane select block: strap codes, register map,
// reset values and the settle count used before the assignment is latched.
// assumes it is included by its bare name, once per compile unit.
//
// Operation
// - combo 1 picks storage 1 or expansion 10
// - combo 1 strap 11 follows storage-1 pin
// - combo 3 picks storage 1 or expansion 14
// - combo 3 strap 11 follows storage-1 pin
// - storage 1 sits on lane 10 or 14
// - combo 4 picks storage 2 or expansion 15
// - combo 4 strap 11 follows storage-2 pin
// - combo 5 picks storage 3 or expansion 16
// - combo 5 strap 11 follows storage-3 pin
// - combo 2 strap 11 follows storage-0 pin
// - storage lanes run at three generation rates
`ifndef CLS_DEFS_SVH
`define CLS_DEFS_SVH

// lane select strap codes
`define CLS_STRAP_STORAGE  2'h1
`define CLS_STRAP_PIN      2'h3

// storage link rate codes, two bits per storage port
`define CLS_RATE_GEN1      2'h1
`define CLS_RATE_GEN2      2'h2
`define CLS_RATE_GEN3      2'h3
`define CLS_RATE_RST       8'hFF

// register word indices; the byte address is four times the index
`define CLS_ADDR_STATUS    6'h00
`define CLS_ADDR_STRAPS    6'h01
`define CLS_ADDR_RATE      6'h02

// status field positions
`define CLS_ST_LOCK_BIT    8
`define CLS_ST_CONF_BIT    9
`define CLS_ST_INSTB_BIT   10

// straps field positions
`define CLS_SP_POL_LSB     16
`define CLS_SP_PIN_LSB     24

// wait count reached after reset release before the straps are sampled
`define CLS_SETTLE_CYC     4'h3

// axi responses
`define CLS_RESP_OKAY      2'h0
`define CLS_RESP_SLVERR    2'h2

`endif

// [pkg/cls_pkg.sv]
// types shared by the combo lane select block.
// assumes cls_defs.svh sits beside it on the include path.
`default_nettype none
package cls_pkg;

  // lane word carried between controllers and lane pins
  typedef struct packed {
    logic        valid;
    logic [19:0] data;
  } cls_lane_t;

  // latch sequence, gray along wait -> sample -> lock
  typedef enum logic [1:0] {
    CLS_WAIT   = 2'h0,
    CLS_SAMPLE = 2'h1,
    CLS_LOCK   = 2'h3
  } cls_state_t;

endpackage
`default_nettype wire

// [logic/cls_sync2.sv]
// two flip-flop synchroniser for slow level inputs.
// assumes each bit is a quasi-static level; no bus coherency across bits.
`timescale 1ns/1ns
`default_nettype none
module cls_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// [logic/cls_lane_select.sv]
// combo lane select: steers five shared lanes to storage or expansion
// controllers, from soft straps and polarity pins latched after reset,
// with an axi4-lite slave for status and storage link rate.
// assumes the soft straps come from a loader on clk_sys and stay stable
// around reset release; polarity pins are asynchronous board levels.
`timescale 1ns/1ns
`default_nettype none
`include "cls_defs.svh"
module cls_lane_select #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [1:0]        combo1_lane_select_strap,
  input  wire logic [1:0]        combo2_lane_select_strap,
  input  wire logic [1:0]        combo3_lane_select_strap,
  input  wire logic [1:0]        combo4_lane_select_strap,
  input  wire logic [1:0]        combo5_lane_select_strap,
  input  wire logic              combo1_polarity_strap,
  input  wire logic              combo2_polarity_strap,
  input  wire logic              combo3_polarity_strap,
  input  wire logic              combo4_polarity_strap,
  input  wire logic              combo5_polarity_strap,
  input  wire logic              storage0_polarity_select_pin,
  input  wire logic              storage1_polarity_select_pin,
  input  wire logic              storage2_polarity_select_pin,
  input  wire logic              storage3_polarity_select_pin,
  input  wire cls_pkg::cls_lane_t sto_tx      [4],
  input  wire cls_pkg::cls_lane_t exp_tx      [5],
  input  wire cls_pkg::cls_lane_t lane_rx     [5],
  output cls_pkg::cls_lane_t     lane_tx     [5],
  output cls_pkg::cls_lane_t     sto_rx      [4],
  output cls_pkg::cls_lane_t     exp_rx      [5],
  output logic [4:0]             lane_is_storage,
  output logic [3:0]             storage_en,
  output logic                   storage1_inst_b,
  output logic [7:0]             storage_rate,
  output logic                   assign_locked,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // every assertion below runs on clk_sys and sleeps through reset
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // lane i (combo i+1) -> storage port; the polarity pin shares its index
  localparam int STO_OF [5] = '{1, 0, 1, 2, 3};

  ////////////////////////////////////////////////////////////////////////
  // strap gathering and pin synchronisers
  logic [9:0] strap_v;
  logic [4:0] pol_v;
  logic [3:0] pin_raw;
  logic [3:0] pin_s;

  assign strap_v = {combo5_lane_select_strap, combo4_lane_select_strap,
                    combo3_lane_select_strap, combo2_lane_select_strap,
                    combo1_lane_select_strap};
  assign pol_v   = {combo5_polarity_strap, combo4_polarity_strap,
                    combo3_polarity_strap, combo2_polarity_strap,
                    combo1_polarity_strap};
  assign pin_raw = {storage3_polarity_select_pin,
                    storage2_polarity_select_pin,
                    storage1_polarity_select_pin,
                    storage0_polarity_select_pin};

  cls_sync2 #(
    .W (4)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-lane decision, evaluated every cycle but latched only once
  logic [4:0] want_sto;
  logic [4:0] pick;
  logic       conflict;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_want
      // strap 11 hands the choice to the pin; other codes but 01 mean
      // expansion, so an unprogrammed strap keeps the expansion port
      always_comb begin
        case (strap_v[2*gi +: 2])
          `CLS_STRAP_STORAGE: want_sto[gi] = 1'b1;
          `CLS_STRAP_PIN:     want_sto[gi] = pin_s[STO_OF[gi]] ^ pol_v[gi];
          default:            want_sto[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  // storage 1 has one controller: combo 1 wins, combo 3 falls back
  assign conflict = want_sto[0] & want_sto[2];
  assign pick     = {want_sto[4:3], want_sto[2] & ~want_sto[0],
                     want_sto[1:0]};

  ////////////////////////////////////////////////////////////////////////
  // latch sequence
  cls_pkg::cls_state_t st_q;
  logic [3:0]          wait_q;
  logic [4:0]          sel_q;
  logic                conf_q;
  logic [9:0]          strap_q;
  logic [4:0]          pol_q;
  logic [3:0]          pin_q;

  // waits for the pin synchronisers to fill before sampling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q   <= cls_pkg::CLS_WAIT;
      wait_q <= 4'h0;
    end else begin
      case (st_q)
        cls_pkg::CLS_WAIT: begin
          wait_q <= wait_q + 4'h1;
          if (wait_q == `CLS_SETTLE_CYC) begin
            st_q <= cls_pkg::CLS_SAMPLE;
          end
        end
        cls_pkg::CLS_SAMPLE: st_q <= cls_pkg::CLS_LOCK;
        cls_pkg::CLS_LOCK:   st_q <= cls_pkg::CLS_LOCK;
        default:             st_q <= cls_pkg::CLS_WAIT;
      endcase
    end
  end

  // assignment is captured once; before that every lane stays expansion
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sel_q   <= 5'h00;
      conf_q  <= 1'b0;
      strap_q <= 10'h000;
      pol_q   <= 5'h00;
      pin_q   <= 4'h0;
    end else if (st_q == cls_pkg::CLS_SAMPLE) begin
      sel_q   <= pick;
      conf_q  <= conflict;
      strap_q <= strap_v;
      pol_q   <= pol_v;
      pin_q   <= pin_s;
    end
  end

  assign lane_is_storage = sel_q;
  assign assign_locked   = (st_q == cls_pkg::CLS_LOCK);
  assign storage1_inst_b = sel_q[2];
  assign storage_en      = {sel_q[4], sel_q[3], sel_q[0] | sel_q[2],
                            sel_q[1]};

  ////////////////////////////////////////////////////////////////////////
  // lane data steering, registered in both directions
  generate
    for (gi = 0; gi < 5; gi++) begin : g_lane
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          lane_tx[gi] <= '0;
          exp_rx[gi]  <= '0;
        end else begin
          lane_tx[gi] <= sel_q[gi] ? sto_tx[STO_OF[gi]] : exp_tx[gi];
          exp_rx[gi]  <= sel_q[gi] ? '0 : lane_rx[gi];
        end
      end
    end
  endgenerate

  // storage receive: storage 1 listens on lane 10 or lane 14
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sto_rx[0] <= '0;
      sto_rx[1] <= '0;
      sto_rx[2] <= '0;
      sto_rx[3] <= '0;
    end else begin
      sto_rx[0] <= sel_q[1] ? lane_rx[1] : '0;
      sto_rx[1] <= sel_q[0] ? lane_rx[0] :
                   (sel_q[2] ? lane_rx[2] : '0);
      sto_rx[2] <= sel_q[3] ? lane_rx[3] : '0;
      sto_rx[3] <= sel_q[4] ? lane_rx[4] : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_have;
  logic              w_have;
  logic              do_wr;
  logic [5:0]        wr_idx;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [7:0]        rate_q;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign aw_have = aw_hold_q | (s_axi_awvalid & s_axi_awready);
  assign w_have  = w_hold_q | (s_axi_wvalid & s_axi_wready);
  assign do_wr   = aw_have & w_have & ~s_axi_bvalid;
  assign wr_idx  = aw_hold_q ? aw_addr_q[7:2] : s_axi_awaddr[7:2];
  assign wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;

  // address and data may come in either order; each is parked until both
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // response one cycle after both halves are present
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CLS_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_idx == `CLS_ADDR_RATE) ? `CLS_RESP_OKAY
                                                 : `CLS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // rate fields: a code of 00 is not a rate, so such a field is left as is
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rate_q <= `CLS_RATE_RST;
    end else if (do_wr && wr_idx == `CLS_ADDR_RATE && wr_strb[0]) begin
      for (int p = 0; p < 4; p++) begin
        if (wr_data[2*p +: 2] != 2'h0) begin
          rate_q[2*p +: 2] <= wr_data[2*p +: 2];
        end
      end
    end
  end

  // rate only offered to a storage port that owns a lane
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rate
      assign storage_rate[2*gi +: 2] =
        storage_en[gi] ? rate_q[2*gi +: 2] : 2'h0;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic [5:0] rd_idx;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[7:2];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CLS_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `CLS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (rd_idx)
        `CLS_ADDR_STATUS: begin
          s_axi_rdata[4:0]               <= sel_q;
          s_axi_rdata[`CLS_ST_LOCK_BIT]  <= assign_locked;
          s_axi_rdata[`CLS_ST_CONF_BIT]  <= conf_q;
          s_axi_rdata[`CLS_ST_INSTB_BIT] <= storage1_inst_b;
        end
        `CLS_ADDR_STRAPS: begin
          s_axi_rdata[9:0]                      <= strap_q;
          s_axi_rdata[`CLS_SP_POL_LSB +: 5]     <= pol_q;
          s_axi_rdata[`CLS_SP_PIN_LSB +: 4]     <= pin_q;
        end
        `CLS_ADDR_RATE:   s_axi_rdata[7:0] <= rate_q;
        default:          s_axi_rresp      <= `CLS_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  logic sampling;
  assign sampling = (st_q == cls_pkg::CLS_SAMPLE);

  a_combo1_default: assert property (
    sampling && strap_v[1:0] != `CLS_STRAP_STORAGE
             && strap_v[1:0] != `CLS_STRAP_PIN |=> !sel_q[0])
    else $error("combo 1 left expansion without a strap");
  a_combo1_pin: assert property (
    sampling && strap_v[1:0] == `CLS_STRAP_PIN
    |=> sel_q[0] == $past(pin_s[1] ^ pol_v[0]))
    else $error("combo 1 ignored the storage-1 pin");
  a_combo3_default: assert property (
    sampling && strap_v[5:4] != `CLS_STRAP_STORAGE
             && strap_v[5:4] != `CLS_STRAP_PIN |=> !sel_q[2])
    else $error("combo 3 left expansion without a strap");
  a_combo3_pin: assert property (
    sampling && strap_v[5:4] == `CLS_STRAP_PIN && !want_sto[0]
    |=> sel_q[2] == $past(pin_s[1] ^ pol_v[2]))
    else $error("combo 3 ignored the storage-1 pin");
  a_storage1_single: assert property (
    !(sel_q[0] && sel_q[2]) &&
    (storage_en[1] == (sel_q[0] || sel_q[2])))
    else $error("storage 1 owns two lanes or none wrongly");
  a_combo4_storage: assert property (
    sampling && strap_v[7:6] == `CLS_STRAP_STORAGE
    |=> sel_q[3] ##1 storage_en[2])
    else $error("combo 4 strap did not give storage 2");
  a_combo4_pin: assert property (
    sampling && strap_v[7:6] == `CLS_STRAP_PIN
    |=> sel_q[3] == $past(pin_s[2] ^ pol_v[3]))
    else $error("combo 4 ignored the storage-2 pin");
  a_combo5_default: assert property (
    sampling && strap_v[9:8] == 2'h0 |=> !sel_q[4] ##1 !storage_en[3])
    else $error("combo 5 left expansion without a strap");
  a_combo5_pin: assert property (
    sampling && strap_v[9:8] == `CLS_STRAP_PIN
    |=> sel_q[4] == $past(pin_s[3] ^ pol_v[4]))
    else $error("combo 5 ignored the storage-3 pin");
  a_combo2_pin: assert property (
    sampling && strap_v[3:2] == `CLS_STRAP_PIN
    |=> sel_q[1] == $past(pin_s[0] ^ pol_v[1]))
    else $error("combo 2 ignored the storage-0 pin");
  a_rate_legal: assert property (
    storage_en[2] |-> storage_rate[5:4] != 2'h0)
    else $error("storage lane offered without a rate");
  a_lock_static: assert property (
    assign_locked |=> assign_locked && $stable(sel_q))
    else $error("lane assignment moved after lock");

endmodule
`default_nettype wire

// [sim/cls_lane_partner.sv]
// far-side model: drive or card answering on all five shared lanes.
// assumes clk_sys from the bench; it never drives out of turn.
`timescale 1ns/1ns
`default_nettype none
module cls_lane_partner (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire cls_pkg::cls_lane_t lane_tx [5],
  output cls_pkg::cls_lane_t      lane_rx [5]
);
  logic [20:0] lfsr_q;

  ////////////////////////////////////////
  // new pattern every cycle so a stale word never passes for fresh
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lfsr_q <= 21'h1ACE1;
    end else begin
      lfsr_q <= {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]};
    end
  end

  // each lane echoes what it heard, mixed with its own twist of the pattern
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      lane_rx[i] = lfsr_q ^ 21'(i * 21'h0F0F1) ^ lane_tx[i];
    end
  end
endmodule
`default_nettype wire

// [sim/cls_lane_select_test.sv]
// self-checking bench: reset-time lane routing, lane data paths and the
// status and rate registers, against a model built in the bench.
// assumes the package, design and lane partner are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "cls_defs.svh"
module cls_lane_select_test;
  logic               clk_sys = 1'b0;
  logic               rstn = 1'b0;
  logic [4:0][1:0]    strap = '0;
  logic [4:0]         pol = '0;
  logic [3:0]         pin = '0;
  cls_pkg::cls_lane_t sto_tx [4] = '{default: '0};
  cls_pkg::cls_lane_t exp_tx [5] = '{default: '0};
  cls_pkg::cls_lane_t lane_rx [5], lane_tx [5], exp_rx [5], sto_rx [4];
  logic [4:0]         lane_is_storage, esel;
  logic [3:0]         storage_en, en;
  logic [7:0]         storage_rate, rate_m;
  logic               storage1_inst_b, assign_locked;
  logic [7:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  int                 lmap [5] = '{1, 0, 1, 2, 3};
  int                 err_count = 0;
  int                 compares = 0;

  always #4 clk_sys = ~clk_sys;

  cls_lane_select dut (
    .clk_sys, .rstn, .sto_tx, .exp_tx, .lane_rx, .lane_tx, .sto_rx,
    .exp_rx, .lane_is_storage, .storage_en, .storage1_inst_b,
    .storage_rate, .assign_locked,
    .combo1_lane_select_strap(strap[0]), .combo2_lane_select_strap(strap[1]),
    .combo3_lane_select_strap(strap[2]), .combo4_lane_select_strap(strap[3]),
    .combo5_lane_select_strap(strap[4]),
    .combo1_polarity_strap(pol[0]), .combo2_polarity_strap(pol[1]),
    .combo3_polarity_strap(pol[2]), .combo4_polarity_strap(pol[3]),
    .combo5_polarity_strap(pol[4]),
    .storage0_polarity_select_pin(pin[0]),
    .storage1_polarity_select_pin(pin[1]),
    .storage2_polarity_select_pin(pin[2]),
    .storage3_polarity_select_pin(pin[3]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  cls_lane_partner partner (.clk_sys, .rstn, .lane_tx, .lane_rx);

  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge clk_sys);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // storage k listens on lane k+1, storage 1 on lane 0 or else lane 2
  function automatic logic [20:0] sto_exp(int k, cls_pkg::cls_lane_t lr [5]);
    if (k == 1) return esel[0] ? lr[0] : (esel[2] ? lr[2] : 21'h0);
    return esel[k + 1] ? lr[k + 1] : 21'h0;
  endfunction

  // every routed output word is the input word of one cycle before; unrouted ones are zero
  task automatic lane_check();
    cls_pkg::cls_lane_t st [4];
    cls_pkg::cls_lane_t et [5];
    cls_pkg::cls_lane_t lr [5];
    for (int n = 0; n < 4; n++) begin
      @(posedge clk_sys);
      for (int k = 0; k < 5; k++) begin
        exp_tx[k] <= 21'($urandom);
        if (k < 4) sto_tx[k] <= 21'($urandom);
      end
      #1;
      for (int k = 0; k < 5 && n > 0; k++) begin
        check(lane_tx[k], esel[k] ? st[lmap[k]] : et[k], "tx");
        check(exp_rx[k], esel[k] ? 21'h0 : lr[k], "exp rx");
        if (k < 4) check(sto_rx[k], sto_exp(k, lr), "sto rx");
      end
      st = sto_tx;
      et = exp_tx;
      lr = lane_rx;
    end
  endtask

  ////////////////////////////////////////
  // first four resets put one strap code on every combo, then random
  initial begin
    logic [1:0]  r;
    logic [31:0] d;
    logic        clash;
    void'($urandom(32'hD0BB9255));
    for (int n = 0; n < 12; n++) begin
      @(posedge clk_sys);
      rstn <= 1'b0;
      strap <= (n < 4) ? {5{2'(n)}} : 10'($urandom);
      pol <= 5'($urandom);
      pin <= 4'($urandom);
      rate_m = `CLS_RATE_RST;
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 5; i++)
        esel[i] = strap[i] == `CLS_STRAP_STORAGE ||
                  (strap[i] == `CLS_STRAP_PIN && (pin[lmap[i]] ^ pol[i]));
      clash = esel[0] && esel[2];
      esel[2] = esel[2] && !clash;
      en = {esel[4:3], esel[0] | esel[2], esel[1]};
      repeat (3) @(posedge clk_sys);
      #1 check(assign_locked, 1'b0, "early lock");
      repeat (3) @(posedge clk_sys);
      #1 check(assign_locked, 1'b1, "lock");
      check(lane_is_storage[0], esel[0], "combo1");
      check(lane_is_storage[1], esel[1], "combo2");
      check(lane_is_storage[2], esel[2], "combo3");
      check(lane_is_storage[3], esel[3], "combo4");
      check(lane_is_storage[4], esel[4], "combo5");
      if (strap[0] == `CLS_STRAP_PIN)
        check(lane_is_storage[0], pin[1] ^ pol[0], "pin a");
      if (strap[2] == `CLS_STRAP_PIN)
        check(lane_is_storage[2], (pin[1] ^ pol[2]) & !esel[0], "b");
      if (strap[3] == `CLS_STRAP_PIN)
        check(lane_is_storage[3], pin[2] ^ pol[3], "pin c");
      if (strap[4] == `CLS_STRAP_PIN)
        check(lane_is_storage[4], pin[3] ^ pol[4], "pin d");
      check(storage_en, en, "enable");
      check(storage1_inst_b, esel[2], "inst b");
      axi_rd(8'h00, d, r);
      check(d, {21'h0, esel[2], clash, 1'b1, 3'h0, esel}, "status");
      axi_rd(8'h04, d, r);
      check(d, {4'h0, pin, 3'h0, pol, 6'h0, strap}, "straps");
      d = $urandom;
      axi_wr(8'h08, d, r);
      check(r, `CLS_RESP_OKAY, "rate wr");
      for (int k = 0; k < 4; k++)
        if (d[2*k +: 2] != 2'h0) rate_m[2*k +: 2] = d[2*k +: 2];
      // a refused write must leave the rate fields alone
      axi_wr(8'h00, 32'h00000055, r);
      check(r, `CLS_RESP_SLVERR, "ro wr");
      // byte 0 strobe off: the rate write is answered but stores nothing
      s_axi_wstrb <= 4'hE;
      axi_wr(8'h08, 32'h00000055, r);
      check(r, `CLS_RESP_OKAY, "masked wr");
      s_axi_wstrb <= 4'hF;
      axi_rd(8'h0C, d, r);
      check(r, `CLS_RESP_SLVERR, "unmapped");
      check(d, 32'h0, "unmapped data");
      axi_rd(8'h08, d, r);
      check(d, {24'h0, rate_m}, "rate rd");
      #1 check(storage_rate, rate_m & {{2{en[3]}}, {2{en[2]}}, {2{en[1]}},
                                        {2{en[0]}}}, "rate out");
      lane_check();
      // straps and pins moving after lock must not move any lane
      strap <= 10'($urandom);
      pol <= 5'($urandom);
      pin <= ~pin;
      repeat (8) @(posedge clk_sys);
      #1 check(lane_is_storage, esel, "static");
    end
    stop_test();
  end

  // about 700 cycles are needed; a hang ends here as a mismatch
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end
endmodule
`default_nettype wire
